// ==== design/bstap_pkg.sv ====
// Constants, state and carrier types for the boundary scan test access port
package bstap_pkg;

  localparam int IR_W = 8;
  localparam int BSR_W = 18;
  localparam int BCR_W = 2;
  localparam int SYNC_DEPTH = 2;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [IR_W-1:0] IR_RESET = 8'hff;
  localparam logic [BCR_W-1:0] BCR_RESET = 2'h2;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic [BSR_W-1:0] BSR_RESET = 18'h00000;

  // Opcodes, bit 7 dropped
  localparam logic [6:0] OP_EXTEST = 7'h00;
  localparam logic [6:0] OP_SAMPLE = 7'h02;
  localparam logic [6:0] OP_INTEST = 7'h03;
  localparam logic [6:0] OP_HIGHZ = 7'h06;
  localparam logic [6:0] OP_CLAMP = 7'h07;
  localparam logic [6:0] OP_RUNT = 7'h09;
  localparam logic [6:0] OP_READBN = 7'h0a;
  localparam logic [6:0] OP_READBT = 7'h0b;
  localparam logic [6:0] OP_CELLTST = 7'h0c;
  localparam logic [6:0] OP_TOGGLE = 7'h0d;
  localparam logic [6:0] OP_SCANCN = 7'h0e;
  localparam logic [6:0] OP_SCANCT = 7'h0f;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bstap_state_t;

  typedef enum logic [1:0] {DR_BYPASS, DR_BOUNDARY, DR_CONTROL} bstap_dr_t;

  // Pin image in boundary chain order, bit 17 first
  typedef struct packed {
    logic [1:0] enableN;
    logic [7:0] dataIn;
    logic [7:0] dataOut;
  } bstap_pins_t;

  // Settings handed from the test clock to the system clock
  typedef struct packed {
    logic highZ;
    logic testMode;
    bstap_pins_t cells;
  } bstap_ctrl_t;

endpackage

// ==== design/bstap_tap.sv ====
// Test access port, instruction and data registers, and pin buffer of the octal test device
`timescale 1ns/1ps
module bstap_tap (
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Test access port, clocked by tck
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOe,
  // Normal-function pins; index 1 is group 1
  input wire logic [1:0] groupOutputEnableN,
  input wire logic [7:0] groupDataInputs,
  output logic [7:0] groupDataOutputs,
  output logic [1:0] groupDataOutputsOe
);

  // How the block hangs together:
  // - Controller state, capture and shift stages move on the rising test clock edge.
  // - Shadow stages and the serial output move on the falling edge, half a period later,
  //   so the far end always sees a bit that has stood since the previous falling edge.
  // - The buffer itself runs on the system clock; its pins never wait for a scan.
  // - Settings reach the system clock as one word, announced by a toggle bit.
  // - The pin image reaches the test clock through two stages. Pins are independent, so
  //   a word caught mid-change is only a sample taken a moment earlier or later.
  // - Power reset comes in on the system clock and is copied onto the test clock, so
  //   the test clock must run while reset is held.
  // Limitations:
  // - Run-test, toggle and self-test operations exist only as modes; nothing runs.
  // - The boundary-control register is scanned and held but steers nothing.
  // - Two settings changes within a few system clocks of each other may be caught
  //   mid-change; scans are far slower than that, so it does not arise in use.
  // - The serial output parks low while released; a pull-up outside gives the high.
  // - Capture of the driven outputs lags the buffer by the crossing, a few clocks.

  // Test clock domain state
  bstap_pkg::bstap_state_t state;
  bstap_pkg::bstap_state_t stateNext;
  logic tckRstn;
  logic [bstap_pkg::IR_W-1:0] irShift;
  logic [bstap_pkg::IR_W-1:0] irReg;
  logic [bstap_pkg::BSR_W-1:0] bsrShift;
  logic [bstap_pkg::BSR_W-1:0] bsrShadow;
  logic [bstap_pkg::BCR_W-1:0] bcrShift;
  logic [bstap_pkg::BCR_W-1:0] bcrShadow;
  logic bypassShift;
  logic tdoReg;
  logic tdoOeReg;
  bstap_pkg::bstap_pins_t snapSync;
  bstap_pkg::bstap_ctrl_t crossReg;
  logic crossTgl;

  // System clock domain state
  logic [9:0] pinSync;
  bstap_pkg::bstap_pins_t pinSnap;
  logic [2:0] tglSync;
  bstap_pkg::bstap_ctrl_t ctrlClk;
  logic [7:0] dataOutReg;
  logic [1:0] dataOeReg;

  // Reset for the test clock side, caught on tck from the system reset
  bstap_sync #(
    .WIDTH(1)
  ) tckRstSync (
    .clk(tck),
    .d(rstn),
    .q(tckRstn)
  );

  // Instruction decode; bit 7 is never looked at
  wire [6:0] opcode = irReg[6:0];

  // One strobe per implemented opcode; any other code falls through to bypass
  wire isExtest = (opcode == bstap_pkg::OP_EXTEST);
  wire isSample = (opcode == bstap_pkg::OP_SAMPLE);
  wire isIntest = (opcode == bstap_pkg::OP_INTEST);
  wire isHighz = (opcode == bstap_pkg::OP_HIGHZ);
  wire isClamp = (opcode == bstap_pkg::OP_CLAMP);
  wire isRunt = (opcode == bstap_pkg::OP_RUNT);
  wire isReadbn = (opcode == bstap_pkg::OP_READBN);
  wire isReadbt = (opcode == bstap_pkg::OP_READBT);
  wire isCelltst = (opcode == bstap_pkg::OP_CELLTST);
  wire isToggle = (opcode == bstap_pkg::OP_TOGGLE);
  wire isScancn = (opcode == bstap_pkg::OP_SCANCN);
  wire isScanct = (opcode == bstap_pkg::OP_SCANCT);

  // Data register placed in the scan path
  wire selBoundary = isExtest || isSample || isIntest || isReadbn || isReadbt || isCelltst;
  wire selControl = isScancn || isScanct;
  // Everything else lands on bypass, including unknown codes
  wire bstap_pkg::bstap_dr_t drSel = selBoundary ? bstap_pkg::DR_BOUNDARY :
                                     selControl ? bstap_pkg::DR_CONTROL :
                                     bstap_pkg::DR_BYPASS;

  // Test mode hands the pins over to the boundary cells
  wire testMode = isExtest || isIntest || isHighz || isClamp || isRunt || isReadbt ||
                  isToggle || isScanct;
  // High-impedance mode also drops every output enable
  wire highZ = isHighz;
  // Read-back instructions capture the cells themselves rather than the pins
  wire readBack = isReadbn || isReadbt || isCelltst;

  // State decode
  wire inCapDr = (state == bstap_pkg::ST_CAP_DR);
  wire inShDr = (state == bstap_pkg::ST_SHIFT_DR);
  wire inCapIr = (state == bstap_pkg::ST_CAP_IR);
  wire inShIr = (state == bstap_pkg::ST_SHIFT_IR);
  wire inShift = inShDr || inShIr;

  // Serial bit presented at the scan path end
  wire drLsb = (drSel == bstap_pkg::DR_BOUNDARY) ? bsrShift[0] :
               (drSel == bstap_pkg::DR_CONTROL) ? bcrShift[0] : bypassShift;
  wire serialLsb = inShIr ? irShift[0] : drLsb;

  // Next state from the mode select level at the rising edge
  always_comb begin
    stateNext = state;
    unique case (state)
      bstap_pkg::ST_RESET: stateNext = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_IDLE: stateNext = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_DR: stateNext = tms ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
      bstap_pkg::ST_CAP_DR: stateNext = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_SHIFT_DR: stateNext = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_EXIT1_DR: stateNext = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_PAUSE_DR: stateNext = tms ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
      bstap_pkg::ST_EXIT2_DR: stateNext = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SHIFT_DR;
      bstap_pkg::ST_UPD_DR: stateNext = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_IR: stateNext = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAP_IR;
      bstap_pkg::ST_CAP_IR: stateNext = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_SHIFT_IR: stateNext = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_EXIT1_IR: stateNext = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_PAUSE_IR: stateNext = tms ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
      bstap_pkg::ST_EXIT2_IR: stateNext = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SHIFT_IR;
      bstap_pkg::ST_UPD_IR: stateNext = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
    endcase
  end

  // Controller state; every high branch heads toward reset within five edges
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      state <= bstap_pkg::ST_RESET;
    end else begin
      state <= stateNext;
    end
  end

  // Instruction shift stage; exit and pause states simply hold it
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      irShift <= bstap_pkg::IR_CAPTURE;
    end else if (inCapIr) begin
      irShift <= bstap_pkg::IR_CAPTURE;
    end else if (inShIr) begin
      irShift <= {tdi, irShift[bstap_pkg::IR_W-1:1]};
    end
  end

  // Boundary shift stage; only power-up clears it, the reset state does not
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      bsrShift <= bstap_pkg::BSR_RESET;
    end else if (inCapDr && selBoundary) begin
      bsrShift <= readBack ? bsrShadow : snapSync;
    end else if (inShDr && selBoundary) begin
      bsrShift <= {tdi, bsrShift[bstap_pkg::BSR_W-1:1]};
    end
  end

  // Boundary-control shift stage keeps its value through capture
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      bcrShift <= bstap_pkg::BCR_RESET;
    end else if (inShDr && selControl) begin
      bcrShift <= {tdi, bcrShift[bstap_pkg::BCR_W-1:1]};
    end
  end

  // Bypass: a lone shift stage with no shadow
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      bypassShift <= bstap_pkg::BYPASS_CAPTURE;
    end else if (inCapDr && (drSel == bstap_pkg::DR_BYPASS)) begin
      bypassShift <= bstap_pkg::BYPASS_CAPTURE;
    end else if (inShDr && (drSel == bstap_pkg::DR_BYPASS)) begin
      bypassShift <= tdi;
    end
  end

  // Pin image from the system clock, two stages before use
  bstap_sync #(
    .WIDTH(bstap_pkg::BSR_W)
  ) snapSyncInst (
    .clk(tck),
    .d(pinSnap),
    .q(snapSync)
  );

  // Current instruction shadow, loaded on the falling edge
  always_ff @(negedge tck) begin
    if (!tckRstn || (state == bstap_pkg::ST_RESET)) begin
      irReg <= bstap_pkg::IR_RESET;
    end else if (state == bstap_pkg::ST_UPD_IR) begin
      irReg <= irShift;
    end
  end

  // Boundary shadow holds across the reset state
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      bsrShadow <= bstap_pkg::BSR_RESET;
    end else if ((state == bstap_pkg::ST_UPD_DR) && selBoundary) begin
      bsrShadow <= bsrShift;
    end
  end

  // Boundary-control shadow returns to its default in the reset state
  always_ff @(negedge tck) begin
    if (!tckRstn || (state == bstap_pkg::ST_RESET)) begin
      bcrShadow <= bstap_pkg::BCR_RESET;
    end else if ((state == bstap_pkg::ST_UPD_DR) && selControl) begin
      bcrShadow <= bcrShift;
    end
  end

  // Serial output drives only in the shift states, changing on falling edges
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      tdoOeReg <= 1'h0;
    end else begin
      tdoOeReg <= inShift;
    end
  end

  // Serial bit; parked low while released so nothing stale leaks out
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      tdoReg <= 1'h0;
    end else begin
      tdoReg <= inShift ? serialLsb : 1'h0;
    end
  end
  assign tdo = tdoReg;
  assign tdoOe = tdoOeReg;

  // Settings word seen by the system clock; toggle marks each change
  wire bstap_pkg::bstap_ctrl_t ctrlNow = '{highZ: highZ, testMode: testMode,
                                          cells: bsrShadow};
  wire ctrlChanged = (ctrlNow != crossReg);

  // Held word; it moves only when the settings move, so the far side reads it settled
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      crossReg <= '0;
    end else if (ctrlChanged) begin
      crossReg <= ctrlNow;
    end
  end

  // Toggle flips with the word; its own crossing gives the word time to settle
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      crossTgl <= 1'h0;
    end else if (ctrlChanged) begin
      crossTgl <= ~crossTgl;
    end
  end

  // Pins into the system clock through two stages
  bstap_sync #(
    .WIDTH(10)
  ) pinSyncInst (
    .clk(clk),
    .d({groupOutputEnableN, groupDataInputs}),
    .q(pinSync)
  );

  // Pin image for capture; data outputs are what the buffer drives now
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinSnap <= '0;
    end else begin
      pinSnap <= '{enableN: pinSync[9:8], dataIn: pinSync[7:0], dataOut: dataOutReg};
    end
  end

  // Toggle synchroniser; the word is steady long before the toggle arrives
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tglSync <= 3'h0;
    end else begin
      tglSync <= {tglSync[1:0], crossTgl};
    end
  end
  wire ctrlLoad = tglSync[2] ^ tglSync[1];

  // Settings in the system clock domain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlClk <= '0;
    end else if (ctrlLoad) begin
      ctrlClk <= crossReg;
    end
  end

  // Output selection: normal inverting buffer, boundary-driven, or all off.
  // Normal mode: each output is the inverse of its input, enabled by its group pin.
  // Test mode: outputs and enables come from the boundary shadow, so a scan that
  // updates the shadow moves the pins a few system clocks later.
  // High-impedance mode wins over both and drops every enable; the data path
  // still follows the shadow so that leaving the mode shows no glitch.
  wire [7:0] normOut = ~pinSync[7:0];
  wire [1:0] normOe = ~pinSync[9:8];
  wire [7:0] outNext = ctrlClk.testMode ? ctrlClk.cells.dataOut : normOut;
  wire [1:0] oeNext = ctrlClk.highZ ? 2'h0 :
                      ctrlClk.testMode ? ~ctrlClk.cells.enableN : normOe;

  // Registered pin data, so every output leaves a flip-flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dataOutReg <= 8'h00;
    end else begin
      dataOutReg <= outNext;
    end
  end

  // Registered group enables; all off during reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dataOeReg <= 2'h0;
    end else begin
      dataOeReg <= oeNext;
    end
  end
  assign groupDataOutputs = dataOutReg;
  assign groupDataOutputsOe = dataOeReg;

endmodule

// Two-stage synchroniser for signals arriving from another clock domain
module bstap_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk,
  // Word from the other domain, and its settled copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] settled;

  // No reset: the stages flush themselves within two clocks
  always_ff @(posedge clk) begin
    meta <= d;
    settled <= meta;
  end
  // Only the second stage is ever read
  assign q = settled;

endmodule

// ==== tb/bstap_ctl_model.sv ====
// Behavioural boundary-scan controller driving the four-wire port
`timescale 1ns/1ps
module bstap_ctl_model (
  // Port lines towards the device
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOe
);
  // Released serial output floats high through its pull-up
  wire tdoLine = tdoOe ? tdo : 1'b1;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One test clock period; the clock stands still between calls
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    #80;
    o = tdoLine;
    tck <= 1'b1;
    #80;
    tck <= 1'b0;
  endtask
  // Full scan from idle, optionally parked in pause after bit pauseAt
  task automatic scan(input logic ir, input logic [17:0] din, input int n, input int pauseAt,
      output logic [17:0] dout);
    logic o;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pauseAt, din[i], o);
      dout[i] = o;
      if (i == pauseAt) begin
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
      end
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// ==== tb/bstap_tap_chk.sv ====
// Checker for the serial side of the test access port
`timescale 1ns/1ps
module bstap_tap_chk (
  // Reset and test clock
  input wire logic rstn,
  input wire logic tck,
  // Serial port
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoOe
);
  // Next state of each state, one nibble each, for mode select high and low
  localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
  localparam logic [63:0] NX0 = 64'h1bddbba146644311;
  logic [3:0] st;
  wire shDr = st == bstap_pkg::ST_SHIFT_DR;
  wire shIr = st == bstap_pkg::ST_SHIFT_IR;
  wire capIr = st == bstap_pkg::ST_CAP_IR;
  // Own copy of the state graph, so no internal signal is needed
  always_ff @(posedge tck) begin
    if (!rstn) begin
      st <= 4'h0;
    end else begin
      st <= tms ? NX1[st*4 +: 4] : NX0[st*4 +: 4];
    end
  end
  default clocking cb @(posedge tck); endclocking
  default disable iff (!rstn);
  a_oe_in_shift: assert property (tdoOe == (shDr || shIr))
    else $error("serial enable does not follow the shift states");
  a_tdo_quiet: assert property (!tdoOe |-> !tdo)
    else $error("serial output not parked low while released");
  a_oe_rise: assert property ($rose(tdoOe) |-> $past(st) inside {4'h3, 4'h7, 4'ha, 4'he})
    else $error("serial output enabled from a wrong state");
  a_oe_drop: assert property ($fell(tdoOe) |-> (st == 4'h5 || st == 4'hc))
    else $error("serial output released outside exit states");
  a_ir_lsb: assert property ((capIr && !tms) |=> tdo ##1 !tdo)
    else $error("captured instruction low bits wrong");
  a_ir_msb: assert property ((capIr && !tms) ##1 shIr [*7] |=> tdo)
    else $error("captured instruction top bit wrong");
  a_ir_pipe: assert property (shIr [*8] ##1 shIr |-> tdo == $past(tdi, 8))
    else $error("instruction path is not eight stages");
  a_reset_five: assert property (tms [*5] |=> !tdoOe [*2])
    else $error("mode select high did not park the port");
endmodule
bind bstap_tap bstap_tap_chk chk (.rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdoOe(tdoOe));

// ==== tb/bstap_tap_tb.sv ====
// Self-checking bench for the test access port
`timescale 1ns/1ps
module bstap_tap_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tck, tms, tdi, tdo, tdoOe;
  logic [1:0] pinEnN = 2'h2;
  logic [7:0] pinIn = 8'h3c;
  logic [7:0] pinOut;
  logic [1:0] pinOe;
  logic [17:0] got;
  int numErrors = 0;
  int nCompared = 0;
  always #12.5 clk = ~clk;
  bstap_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
  bstap_tap uut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .groupOutputEnableN(pinEnN), .groupDataInputs(pinIn),
    .groupDataOutputs(pinOut), .groupDataOutputsOe(pinOe));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] seen);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Test clock cycles with a fixed mode select
  task automatic tk(input logic m, input int n);
    logic o;
    repeat (n) ctl.step(m, 1'b1, o);
  endtask
  // Pins settle through the crossing, so poll a bounded while
  task automatic pins(input logic [7:0] ed, input logic [1:0] ee);
    for (int k = 0; k < 64 && (pinOut !== ed || pinOe !== ee); k++) @(negedge clk);
    chk("pin data", 18'(ed), 18'(pinOut));
    chk("pin enables", 18'(ee), 18'(pinOe));
  endtask
  // Capture pattern out, unknown opcode in, then a bypass scan with a pause
  task automatic t_bypass();
    pins(8'hc3, 2'h1);
    ctl.scan(1'b1, 18'h0085f, 12, 2, got);
    chk("instruction capture", 18'h00f81, got);
    tk(1'b0, 4);
    ctl.scan(1'b0, 18'h0000d, 4, 1, got);
    chk("bypass path", 18'h0000a, got);
    pins(8'hc3, 2'h1);
  endtask
  // Boundary scan with top bit set, update to pins, then read back
  task automatic t_boundary();
    ctl.scan(1'b1, 18'h00080, 8, -1, got);
    tk(1'b0, 4);
    ctl.scan(1'b0, 18'h0a55a, 18, 9, got);
    chk("pin image before", 18'h23c00, got);
    pins(8'h5a, 2'h3);
    tk(1'b0, 4);
    ctl.scan(1'b0, 18'h0a55a, 18, -1, got);
    chk("pin image after", 18'h23c5a, got);
  endtask
  // Five high mode selects restore bypass but keep the chain
  task automatic t_reset_state();
    tk(1'b1, 5);
    tk(1'b0, 1);
    pins(8'hc3, 2'h1);
    ctl.scan(1'b0, 18'h00001, 2, -1, got);
    chk("bypass after reset state", 18'h00002, got);
    ctl.scan(1'b1, 18'h0000a, 8, -1, got);
    ctl.scan(1'b0, 18'h0a55a, 18, -1, got);
    chk("chain kept", 18'h0a55a, got);
    ctl.scan(1'b1, 18'h0000e, 8, -1, got);
    ctl.scan(1'b0, 18'h00000, 2, -1, got);
    chk("control register", 18'(bstap_pkg::BCR_RESET), got);
    ctl.scan(1'b1, 18'h00006, 8, -1, got);
    pins(8'h5a, 2'h0);
  endtask
  initial begin
    #400000;
    numErrors++;
    conclude();
  end
  initial begin
    fork
      repeat (20) @(posedge clk);
      tk(1'b1, 3);
    join
    rstn <= 1'b1;
    tk(1'b1, 3);
    tk(1'b0, 1);
    t_bypass();
    t_boundary();
    t_reset_state();
    conclude();
  end
endmodule
